// [design/sibw_pkg.sv]
package sibw_pkg;
	localparam int REG_COUNT = 4;
	localparam int IDX_W = 8;
	localparam logic [7:0] REF_CTRL_IDX = 8'h03;
	localparam logic [7:0] REF_CTRL_RESET = 8'h5f;
	localparam int REF_RUN_BIT = 5;
	localparam int EDGE_LSB = 6;
	localparam logic [6:0] ADDR_SEL0 = 7'h68;
	localparam logic [6:0] ADDR_SEL1 = 7'h6a;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] REG_DEFAULT = 8'h00;

	typedef enum logic [2:0] {
		SIBW_IDLE = 3'b000,
		SIBW_ADDR = 3'b001,
		SIBW_INDEX = 3'b011,
		SIBW_COUNT = 3'b010,
		SIBW_DATA = 3'b110,
		SIBW_IGNORE = 3'b111
	} sibw_state_t;
endpackage : sibw_pkg

// [design/sibw_target.sv]
`timescale 1ns/1ps
// What this block does
// [R01] Host opens every write with a start condition on the bus.
// [R02] Host sends address plus write bit; device acknowledges a matching address.
// [R03] Device acknowledges the index byte and loads it as register pointer.
// [R04] Device acknowledges the byte count before any data byte.
// [R05] Data bytes land in consecutive registers from the index, for count bytes.
// [R06] Device acknowledges every data byte separately.
// [R07] Host ends the block write with a stop after the last acknowledge.
// [R08] Bus address follows the address-select pin level, latched and held.
// [R09] Reference control bit 5 keeps reference output running in power-down.
// [R10] Reference control value selects reference edge strength; default 0x5f.
// [R11] Out-of-range data bytes are acknowledged and dropped, registers untouched.
module sibw_target #(
	parameter int REGS = sibw_pkg::REG_COUNT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic address_select_pin,
	input wire logic power_down,
	output logic ref_output_run,
	output logic differential_clock_output_run,
	output logic [1:0] ref_edge_strength,
	output logic [7:0] ref_control
);
	// Register file index bits; REGS is meant to be a power of two
	localparam int PTR_W = $clog2(REGS);

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic [1:0] sel_sync;
		logic scl_prev;
		logic sda_prev;
		logic sel_done;
		logic [1:0] sel_wait;
		logic addr_sel;
		sibw_pkg::sibw_state_t state;
		logic [2:0] bitn;
		logic [7:0] shift;
		logic ack_phase;
		logic ack_drive;
		logic ack_window;
		logic [7:0] ptr;
		logic [7:0] count;
		logic [REGS-1:0][7:0] regs;
	} sibw_st_t;

	sibw_st_t s_reg, s_next;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic [7:0] byte_in;
	logic [6:0] my_addr;

	always_comb begin
		scl_rise = s_reg.scl_sync[1] && !s_reg.scl_prev;
		scl_fall = !s_reg.scl_sync[1] && s_reg.scl_prev;
		start_seen = s_reg.scl_sync[1] && s_reg.scl_prev && s_reg.sda_prev && !s_reg.sda_sync[1];
		stop_seen = s_reg.scl_sync[1] && s_reg.scl_prev && !s_reg.sda_prev && s_reg.sda_sync[1];
		byte_in = {s_reg.shift[6:0], s_reg.sda_sync[1]};
		my_addr = s_reg.addr_sel ? sibw_pkg::ADDR_SEL1 : sibw_pkg::ADDR_SEL0; // R08
	end

	always_comb begin
		s_next = s_reg;
		s_next.scl_sync = {s_reg.scl_sync[0], scl_in};
		s_next.sda_sync = {s_reg.sda_sync[0], sda_in};
		s_next.sel_sync = {s_reg.sel_sync[0], address_select_pin};
		s_next.scl_prev = s_reg.scl_sync[1];
		s_next.sda_prev = s_reg.sda_sync[1];
		// The pin is taken once the synchroniser holds it, then frozen so a moving
		// pin cannot retarget the device; there is no power-good input to wait on
		s_next.sel_wait = {s_reg.sel_wait[0], 1'b1};
		if (!s_reg.sel_done && s_reg.sel_wait[1]) begin
			s_next.sel_done = 1'b1; // R08
			s_next.addr_sel = s_reg.sel_sync[1]; // R08
		end
		if (start_seen) begin
			s_next.state = sibw_pkg::SIBW_ADDR; // R01
			s_next.bitn = '0;
			s_next.ack_phase = 1'b0;
			s_next.ack_drive = 1'b0;
			s_next.ack_window = 1'b0;
		end else if (stop_seen) begin
			s_next.state = sibw_pkg::SIBW_IDLE; // R07
			s_next.ack_phase = 1'b0;
			s_next.ack_drive = 1'b0;
			s_next.ack_window = 1'b0;
		end else if (s_reg.state != sibw_pkg::SIBW_IDLE && s_reg.state != sibw_pkg::SIBW_IGNORE) begin
			if (scl_rise && !s_reg.ack_phase) begin
				s_next.shift = byte_in;
				s_next.bitn = s_reg.bitn + 3'h1;
			end
			// Ninth bit is the ack slot: first fall opens the drive, second fall ends it
			if (scl_fall && s_reg.ack_phase) begin
				if (s_reg.ack_window) begin
					s_next.ack_window = 1'b0;
					s_next.ack_drive = 1'b0;
					s_next.ack_phase = 1'b0;
				end else if (s_reg.ack_drive) begin
					s_next.ack_window = 1'b1; // R06
				end else begin
					s_next.ack_phase = 1'b0;
				end
			end
			// Byte complete on the eighth rise; the ack slot follows
			if (scl_rise && !s_reg.ack_phase && s_reg.bitn == sibw_pkg::BIT_LAST) begin
				s_next.ack_phase = 1'b1;
				case (s_reg.state)
					sibw_pkg::SIBW_ADDR: begin
						if (byte_in[7:1] == my_addr && !byte_in[0]) begin
							s_next.ack_drive = 1'b1; // R02
							s_next.state = sibw_pkg::SIBW_INDEX;
						end else begin
							s_next.ack_phase = 1'b0;
							s_next.state = sibw_pkg::SIBW_IGNORE;
						end
					end
					sibw_pkg::SIBW_INDEX: begin
						s_next.ack_drive = 1'b1; // R03
						s_next.ptr = byte_in; // R03
						s_next.state = sibw_pkg::SIBW_COUNT;
					end
					sibw_pkg::SIBW_COUNT: begin
						s_next.ack_drive = 1'b1; // R04
						s_next.count = byte_in;
						s_next.state = sibw_pkg::SIBW_DATA;
					end
					sibw_pkg::SIBW_DATA: begin
						s_next.ack_drive = 1'b1; // R06
						if (s_reg.count != '0) begin
							if (s_reg.ptr < 8'(REGS))
								s_next.regs[s_reg.ptr[PTR_W-1:0]] = byte_in; // R05 R11
							s_next.ptr = s_reg.ptr + 8'h01; // R05
							s_next.count = s_reg.count - 8'h01;
						end
					end
					default: s_next.state = sibw_pkg::SIBW_IGNORE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			// Line history resets to the idle-high bus so no false edge follows reset
			s_reg.scl_sync <= 2'h3;
			s_reg.sda_sync <= 2'h3;
			s_reg.scl_prev <= 1'b1;
			s_reg.sda_prev <= 1'b1;
			s_reg.regs[sibw_pkg::REF_CTRL_IDX[PTR_W-1:0]] <= sibw_pkg::REF_CTRL_RESET; // R10
		end else begin
			s_reg <= s_next;
		end
	end

	// Only low is ever driven; the bus pull-up supplies the high level
	always_comb begin
		sda_out = 1'b0;
		sda_oe = s_reg.ack_window; // R02 R03 R04 R06
		ref_control = s_reg.regs[sibw_pkg::REF_CTRL_IDX[PTR_W-1:0]];
		ref_edge_strength = ref_control[sibw_pkg::EDGE_LSB +: 2]; // R10
		ref_output_run = !power_down || ref_control[sibw_pkg::REF_RUN_BIT]; // R09
		differential_clock_output_run = !power_down; // R09
	end

	// Frame control
	stop_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // R07
		stop_seen |=> s_reg.state == sibw_pkg::SIBW_IDLE)
		else $error("stop not idling");
	start_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // R01
		start_seen |=> s_reg.state == sibw_pkg::SIBW_ADDR)
		else $error("start missed");
	addr_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R08
		s_reg.sel_done |=> $stable(s_reg.addr_sel))
		else $error("address moved");
	addr_miss_a: assert property (@(posedge clk) disable iff (!reset_n) // R02
		scl_rise && !s_reg.ack_phase && s_reg.state == sibw_pkg::SIBW_ADDR
		&& s_reg.bitn == sibw_pkg::BIT_LAST && byte_in[7:1] != my_addr
		|=> s_reg.state == sibw_pkg::SIBW_IGNORE && !s_reg.ack_phase)
		else $error("foreign address taken");
	index_ack_a: assert property (@(posedge clk) disable iff (!reset_n) // R03
		scl_rise && !s_reg.ack_phase && s_reg.state == sibw_pkg::SIBW_INDEX
		&& s_reg.bitn == sibw_pkg::BIT_LAST
		|=> s_reg.ack_drive && s_reg.state == sibw_pkg::SIBW_COUNT)
		else $error("index not acked");
	index_load_a: assert property (@(posedge clk) disable iff (!reset_n) // R03
		$past(s_reg.state) == sibw_pkg::SIBW_INDEX && s_reg.state == sibw_pkg::SIBW_COUNT
		|-> s_reg.ptr == s_reg.shift)
		else $error("index not loaded");
	count_ack_a: assert property (@(posedge clk) disable iff (!reset_n) // R04
		scl_rise && !s_reg.ack_phase && s_reg.state == sibw_pkg::SIBW_COUNT
		&& s_reg.bitn == sibw_pkg::BIT_LAST
		|=> s_reg.ack_drive && s_reg.state == sibw_pkg::SIBW_DATA)
		else $error("count not acked");
	count_load_a: assert property (@(posedge clk) disable iff (!reset_n) // R04
		$past(s_reg.state) == sibw_pkg::SIBW_COUNT && s_reg.state == sibw_pkg::SIBW_DATA
		|-> s_reg.count == s_reg.shift)
		else $error("count not loaded");

	// Data bytes and acknowledge drive
	data_ack_a: assert property (@(posedge clk) disable iff (!reset_n) // R06
		scl_rise && !s_reg.ack_phase && s_reg.state == sibw_pkg::SIBW_DATA
		&& s_reg.bitn == sibw_pkg::BIT_LAST
		|=> s_reg.ack_phase && s_reg.ack_drive)
		else $error("data not acked");
	ptr_step_a: assert property (@(posedge clk) disable iff (!reset_n) // R05
		s_reg.state == sibw_pkg::SIBW_DATA && $past(s_reg.state) == sibw_pkg::SIBW_DATA
		&& s_reg.count != $past(s_reg.count) |-> s_reg.ptr == $past(s_reg.ptr) + 8'h01)
		else $error("pointer step");
	count_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // R05
		s_reg.state == sibw_pkg::SIBW_DATA && s_reg.count == '0 |=> $stable(s_reg.regs))
		else $error("write past count");
	range_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
		s_reg.state == sibw_pkg::SIBW_DATA && s_reg.ptr >= 8'(REGS) |=> $stable(s_reg.regs))
		else $error("out of range write");
	ack_open_a: assert property (@(posedge clk) disable iff (!reset_n) // R06
		scl_fall && s_reg.ack_phase && s_reg.ack_drive && !s_reg.ack_window |=> sda_oe)
		else $error("ack not opened");
	ack_close_a: assert property (@(posedge clk) disable iff (!reset_n) // R06
		scl_fall && s_reg.ack_window |=> !sda_oe)
		else $error("ack held too long");
	ack_low_a: assert property (@(posedge clk) disable iff (!reset_n) // R06
		sda_oe |-> !sda_out && s_reg.ack_phase)
		else $error("ack not low");
	ignore_quiet_a: assert property (@(posedge clk) disable iff (!reset_n) // R02
		s_reg.state == sibw_pkg::SIBW_IGNORE |-> !sda_oe)
		else $error("ignored frame acked");

	// Output control
	ref_run_a: assert property (@(posedge clk) disable iff (!reset_n) // R09
		power_down && !ref_control[sibw_pkg::REF_RUN_BIT] |-> !ref_output_run)
		else $error("ref ran");
	ref_wake_a: assert property (@(posedge clk) disable iff (!reset_n) // R09
		power_down && ref_control[sibw_pkg::REF_RUN_BIT] |-> ref_output_run)
		else $error("ref stopped");
	dif_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // R09
		power_down |-> !differential_clock_output_run)
		else $error("dif ran");
	awake_run_a: assert property (@(posedge clk) disable iff (!reset_n) // R09
		!power_down |-> ref_output_run && differential_clock_output_run)
		else $error("outputs stopped while awake");
endmodule : sibw_target

// [test/sibw_host.sv]
`timescale 1ns/1ps
// Host side; a released line is pulled up
module sibw_host (
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start_bit();
		sda_low = 1'b1;
		#160 scl = 1'b0;
		#80;
	endtask : start_bit
	task automatic stop_bit();
		sda_low = 1'b1;
		#80 scl = 1'b1;
		#80 sda_low = 1'b0;
		#160;
	endtask : stop_bit
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int k = 7; k >= 0; k--) begin
			sda_low = ~b[k];
			#80 scl = 1'b1;
			#160 scl = 1'b0;
			#80;
		end
		sda_low = 1'b0;
		#80 scl = 1'b1;
		#80 ack = ~sda_line;
		#80 scl = 1'b0;
		#80;
	endtask : send_byte
endmodule : sibw_host

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic pin = 1'b0;
	logic pd = 1'b0;
	logic scl, hl, so, oe, rr, dr;
	logic [1:0] es;
	logic [7:0] rc;
	wire sda = ~(hl | (oe & ~so));
	int error_cnt = 0;
	int num_checks = 0;
	always #20 clk = ~clk;
	sibw_host u_host (.scl(scl), .sda_low(hl), .sda_line(sda));
	sibw_target uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(so), .sda_oe(oe), .address_select_pin(pin), .power_down(pd),
		.ref_output_run(rr), .differential_clock_output_run(dr),
		.ref_edge_strength(es), .ref_control(rc));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic rst(input logic sel);
		@(posedge clk) #1 reset_n = 1'b0;
		pin = sel;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (6) @(posedge clk);
	endtask : rst
	// Frame: address, index, count, then nd data bytes
	task automatic xfer(input logic [6:0] a, input logic [15:0] ic, input logic [31:0] d,
		input int nd, input int ea);
		logic [55:0] f;
		logic ack;
		int n;
		f = {a, 1'b0, ic, d};
		n = 0;
		// Host edges land just after a clock edge, never on it
		@(posedge clk) #1;
		u_host.start_bit();
		for (int k = 0; k < nd + 3; k++) begin
			u_host.send_byte(f[55-8*k -: 8], ack);
			n += int'(ack === 1'b1);
		end
		u_host.stop_bit();
		repeat (4) @(posedge clk);
		chk("acks", 8'(ea), 8'(n));
	endtask : xfer
	task automatic t_edge();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {2'(i), 6'h1f};
			xfer(7'h68, 16'h0301, {v, 24'h0}, 1, 4);
			chk("ref_control", v, rc);
			chk("edge", 8'(i), {6'h0, es});
		end
		$display("test edge done");
	endtask : t_edge
	task automatic t_pd();
		xfer(7'h68, 16'h0301, 32'h1f000000, 1, 4);
		#1 pd = 1'b1;
		repeat (2) @(posedge clk);
		chk("ref_run", 8'h00, {7'h0, rr});
		chk("dif_run", 8'h00, {7'h0, dr});
		xfer(7'h68, 16'h0301, 32'h3f000000, 1, 4);
		chk("ref_run", 8'h01, {7'h0, rr});
		#1 pd = 1'b0;
		@(posedge clk);
		chk("ref_awake", 8'h01, {7'h0, rr});
		chk("dif_awake", 8'h01, {7'h0, dr});
		$display("test power done");
	endtask : t_pd
	task automatic t_block();
		xfer(7'h68, 16'h0202, 32'haa9f5500, 3, 6);
		chk("ref_control", 8'h9f, rc);
		xfer(7'h68, 16'h0702, 32'h11220000, 2, 5);
		chk("ref_control", 8'h9f, rc);
		xfer(7'h6a, 16'h0301, 32'h1f000000, 1, 0);
		chk("ref_control", 8'h9f, rc);
		rst(1'b1);
		chk("reset_value", 8'h5f, rc);
		xfer(7'h6a, 16'h0301, 32'hdf000000, 1, 4);
		chk("ref_control", 8'hdf, rc);
		$display("test block done");
	endtask : t_block
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	initial begin
		#1_000_000;
		error_cnt++;
		finish_test();
	end
	initial begin
		rst(1'b0);
		chk("reset_value", 8'h5f, rc);
		t_edge();
		t_pd();
		t_block();
		finish_test();
	end
endmodule : tb_top
